//--- core/irq_group_regs.svh
`ifndef IRQ_GROUP_REGS_SVH
`define IRQ_GROUP_REGS_SVH

// Register byte offsets
`define OFF_CTL 12'h000
`define OFF_PMR 12'h004
`define OFF_BPR 12'h008
`define OFF_IAR 12'h00c
`define OFF_EOIR 12'h010
`define OFF_HPPIR 12'h014
`define OFF_ABPR 12'h018
`define OFF_AIAR 12'h01c
`define OFF_AEOIR 12'h020
`define OFF_AHPPIR 12'h024
`define OFF_DIR 12'h028
`define OFF_STATUS 12'h02c
`define OFF_GROUP 12'h030
`define OFF_PEND 12'h034
`define OFF_ACT 12'h038
`define PRIO_REGION 4'h1

// Interface control fields
`define CTL_G0EN 0
`define CTL_G1EN 1
`define CTL_ACK_CONTROL 2
`define CTL_FAST_EN 3
`define CTL_COMMON_BP 4
`define CTL_FAST_BYP_DIS 5
`define CTL_IRQ_BYP_DIS 6
`define CTL_EOI_S 9
`define CTL_EOI_NS 10
`define CTL_MASK 32'h0000067f
`define CTL_NS_MASK 32'h00000402

// Status fields
`define ST_VALID_BIT 15
`define ST_GRP_BIT 14
`define ST_BP_LSB 16

// Reset values
`define CTL_RST 32'h00000000
`define PMR_RST 8'h00
`define BPR_RST 3'h0
`define GROUP_RST 32'h00000000

// Identifiers
`define ID_W 10
`define BP_W 3
`define ID_SPUR_GRP 10'h3fe
`define ID_SPUR_NONE 10'h3ff
`define ID_FIRST_RSVD 1020

`endif

//--- core/irq_group_pkg.sv
`include "irq_group_regs.svh"
package irq_group_pkg;
  typedef logic [`ID_W-1:0] irq_id_t;
  typedef logic [`BP_W-1:0] bin_point_t;
endpackage : irq_group_pkg

//--- core/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;
endmodule : pin_sync

//--- core/priority_mem.sv
`timescale 1ns/1ps
module priority_mem #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 8,
  parameter int AW = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // Read port, data one cycle later
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] rdata_reg;

  if (DEPTH > (1 << AW)) begin : g_bad_depth
    $error("priority_mem: DEPTH does not fit AW");
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= mem[raddr];
    end
  end

  assign rdata = rdata_reg;
endmodule : priority_mem

//--- core/interrupt_group_ack_logic.sv
`timescale 1ns/1ps
`include "irq_group_regs.svh"
module interrupt_group_ack_logic #(
  parameter int NUM_IRQ = 32,
  parameter int PRIO_W = 8,
  parameter bit SEC_EXT = 1'b1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [2:0] pprot,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt sources and bypass pins
  input wire logic [NUM_IRQ-1:0] irq_src_in,
  input wire logic bypass_irq_in,
  input wire logic bypass_fast_in,
  // Requests to the processor
  output logic irq_req,
  output logic fast_interrupt_request
);
  import irq_group_pkg::*;

  localparam int IDX_W = $clog2(NUM_IRQ);
  localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(NUM_IRQ - 1);

  // Single-word group, pending and active registers; ids stay below the reserved pair
  if (NUM_IRQ < 2 || NUM_IRQ > 32 || NUM_IRQ > `ID_FIRST_RSVD || PRIO_W < 1 || PRIO_W > 8) begin : g_bad_cfg
    $error("interrupt_group_ack_logic: unsupported NUM_IRQ or PRIO_W");
  end

  function automatic logic [NUM_IRQ-1:0] id_onehot(input irq_id_t id, input logic en);
    logic [NUM_IRQ-1:0] v;
    v = '0;
    for (int i = 0; i < NUM_IRQ; i++) begin
      if (en && id == irq_id_t'(i)) begin
        v[i] = 1'b1;
      end
    end
    return v;
  endfunction : id_onehot

  // Returns {acknowledge, identifier} for an ack or highest-pending read
  function automatic logic [`ID_W:0] ack_decide(input logic alias_rd, input logic sec_acc, input logic sig_ok,
                                                input logic grp1, input logic ack_ctl, input irq_id_t id);
    logic [`ID_W:0] r;
    r = {1'b0, `ID_SPUR_NONE};
    if (sig_ok) begin
      if (SEC_EXT && !sec_acc) begin
        r = grp1 ? {1'b1, id} : {1'b0, `ID_SPUR_NONE};
      end else if (alias_rd) begin
        r = grp1 ? {1'b1, id} : {1'b0, `ID_SPUR_NONE};
      end else if (!grp1 || ack_ctl) begin
        r = {1'b1, id};
      end else begin
        r = {1'b0, `ID_SPUR_GRP};
      end
    end
    return r;
  endfunction : ack_decide

  logic [NUM_IRQ-1:0] src_sync;
  logic byp_irq_sync;
  logic byp_fast_sync;
  logic [NUM_IRQ-1:0] src_prev_reg;
  logic [31:0] ctl_reg;
  logic [31:0] ctl_next;
  logic [PRIO_W-1:0] pmr_reg;
  bin_point_t bpr_reg;
  bin_point_t abpr_reg;
  logic [NUM_IRQ-1:0] grp_reg;
  logic [NUM_IRQ-1:0] pend_reg;
  logic [NUM_IRQ-1:0] pend_next;
  logic [NUM_IRQ-1:0] act_reg;
  logic [NUM_IRQ-1:0] act_next;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic err_reg;
  logic ack_take_reg;
  logic [IDX_W-1:0] ack_idx_reg;
  logic irq_req_reg;
  logic fast_req_reg;
  logic [IDX_W-1:0] scan_idx_reg;
  logic [IDX_W-1:0] cmp_idx_reg;
  logic cmp_valid_reg;
  logic cand_valid_reg;
  logic [IDX_W-1:0] cand_idx_reg;
  logic [PRIO_W-1:0] cand_pri_reg;
  logic best_valid_reg;
  logic [IDX_W-1:0] best_idx_reg;
  logic [PRIO_W-1:0] best_pri_reg;
  logic [PRIO_W-1:0] mem_rdata;
  logic [31:0] rd_mux;

  pin_sync #(.W(NUM_IRQ + 2)) u_pin_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({bypass_fast_in, bypass_irq_in, irq_src_in}),
    .q({byp_fast_sync, byp_irq_sync, src_sync})
  );

  // Bus decode
  wire cap = psel & penable & ~pready_reg;
  wire fire = psel & penable & pready_reg;
  wire sec_acc = SEC_EXT ? ~pprot[1] : 1'b1;
  wire ns_acc = SEC_EXT & ~sec_acc;
  wire alias_hit = (paddr == `OFF_ABPR) | (paddr == `OFF_AIAR) | (paddr == `OFF_AEOIR) | (paddr == `OFF_AHPPIR);
  wire prio_hit = (paddr[11:8] == `PRIO_REGION) && ({1'b0, paddr[7:2]} < 7'(NUM_IRQ));
  wire plain_hit = (paddr == `OFF_CTL) | (paddr == `OFF_PMR) | (paddr == `OFF_BPR) | (paddr == `OFF_IAR)
                 | (paddr == `OFF_EOIR) | (paddr == `OFF_HPPIR) | (paddr == `OFF_DIR) | (paddr == `OFF_STATUS)
                 | (paddr == `OFF_GROUP) | (paddr == `OFF_PEND) | (paddr == `OFF_ACT);
  // Aliases are refused to nonsecure accesses with an error answer
  wire refuse = ~(plain_hit | alias_hit | prio_hit) | (ns_acc & alias_hit);
  wire ack_addr = (paddr == `OFF_IAR) | (paddr == `OFF_AIAR);
  wire alias_rd = (paddr == `OFF_AIAR) | (paddr == `OFF_AHPPIR);
  wire wr_ok = fire & pwrite & ~err_reg;
  wire rd_ack = fire & ~pwrite & ack_take_reg;

  // Highest pending view
  wire irq_id_t best_id = irq_id_t'(best_idx_reg);
  wire best_grp1 = grp_reg[best_idx_reg];
  wire sig_ok = best_valid_reg & (best_pri_reg < pmr_reg);
  wire [`ID_W:0] decide = ack_decide(alias_rd, sec_acc, sig_ok, best_grp1, ctl_reg[`CTL_ACK_CONTROL], best_id);
  wire bin_point_t grp1_bp = ctl_reg[`CTL_COMMON_BP] ? bpr_reg : abpr_reg;
  wire bin_point_t bpr_view = ns_acc ? abpr_reg : bpr_reg;
  wire [31:0] status_word = {13'h0000, grp1_bp, best_valid_reg, best_grp1, 4'h0, best_id};

  // Register writes
  wire ctl_wr = wr_ok & (paddr == `OFF_CTL);
  wire [31:0] ctl_wr_val = ns_acc ? ((ctl_reg & ~`CTL_NS_MASK) | (pwdata & `CTL_NS_MASK)) : (pwdata & `CTL_MASK);
  assign ctl_next = ctl_wr ? ctl_wr_val : ctl_reg;
  wire pmr_wr = wr_ok & (paddr == `OFF_PMR);
  wire bpr_wr = wr_ok & (paddr == `OFF_BPR) & ~ns_acc;
  wire abpr_wr = wr_ok & (((paddr == `OFF_BPR) & ns_acc) | (paddr == `OFF_ABPR));
  wire grp_wr = wr_ok & (paddr == `OFF_GROUP) & sec_acc;
  wire prio_we = wr_ok & prio_hit;

  // End of interrupt: mode bit picks EOI or separate deactivate write
  wire eoi_mode = ns_acc ? ctl_reg[`CTL_EOI_NS] : ctl_reg[`CTL_EOI_S];
  wire eoi_hit = wr_ok & ((paddr == `OFF_EOIR) | (paddr == `OFF_AEOIR));
  wire dir_hit = wr_ok & (paddr == `OFF_DIR);
  wire deact_en = (eoi_hit & ~eoi_mode) | (dir_hit & eoi_mode);
  wire [NUM_IRQ-1:0] deact_vec = id_onehot(pwdata[`ID_W-1:0], deact_en);
  wire [NUM_IRQ-1:0] ack_vec = id_onehot(irq_id_t'(ack_idx_reg), rd_ack);
  wire [NUM_IRQ-1:0] src_rise = src_sync & ~src_prev_reg;

  // A source edge in the ack cycle keeps the interrupt pending
  assign pend_next = (pend_reg & ~ack_vec) | src_rise;
  assign act_next = (act_reg & ~deact_vec) | ack_vec;

  always_comb begin
    rd_mux = 32'h00000000;
    case (paddr)
      `OFF_CTL: rd_mux = ns_acc ? (ctl_reg & `CTL_NS_MASK) : ctl_reg;
      `OFF_PMR: rd_mux = 32'(pmr_reg);
      `OFF_BPR: rd_mux = 32'(bpr_view);
      `OFF_ABPR: rd_mux = 32'(abpr_reg);
      `OFF_IAR, `OFF_HPPIR, `OFF_AIAR, `OFF_AHPPIR: rd_mux = 32'(decide[`ID_W-1:0]);
      `OFF_STATUS: rd_mux = status_word;
      `OFF_GROUP: rd_mux = 32'(grp_reg);
      `OFF_PEND: rd_mux = 32'(pend_reg);
      `OFF_ACT: rd_mux = 32'(act_reg);
      default: rd_mux = 32'h00000000;
    endcase
  end

  // One wait state: answer is registered in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      err_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      ack_take_reg <= 1'b0;
      ack_idx_reg <= '0;
    end else begin
      pready_reg <= cap;
      if (cap) begin
        err_reg <= refuse;
        prdata_reg <= (pwrite | refuse) ? 32'h00000000 : rd_mux;
        ack_take_reg <= ~pwrite & ~refuse & ack_addr & decide[`ID_W];
        ack_idx_reg <= best_idx_reg;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_reg <= `CTL_RST;
      pmr_reg <= PRIO_W'(`PMR_RST);
      bpr_reg <= `BPR_RST;
      abpr_reg <= `BPR_RST;
      grp_reg <= NUM_IRQ'(`GROUP_RST);
    end else begin
      ctl_reg <= ctl_next;
      if (pmr_wr) pmr_reg <= pwdata[PRIO_W-1:0];
      if (bpr_wr) bpr_reg <= pwdata[`BP_W-1:0];
      if (abpr_wr) abpr_reg <= pwdata[`BP_W-1:0];
      if (grp_wr) grp_reg <= pwdata[NUM_IRQ-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev_reg <= '0;
      pend_reg <= '0;
      act_reg <= '0;
    end else begin
      src_prev_reg <= src_sync;
      pend_reg <= pend_next;
      act_reg <= act_next;
    end
  end

  priority_mem #(.DEPTH(NUM_IRQ), .WIDTH(PRIO_W), .AW(IDX_W)) u_priority_mem (
    .clk(pclk),
    .rst_n(presetn),
    .we(prio_we),
    .waddr(paddr[IDX_W+1:2]),
    .wdata(pwdata[PRIO_W-1:0]),
    .raddr(scan_idx_reg),
    .rdata(mem_rdata)
  );

  // Sweep scanner; lowest id wins a priority tie
  wire eligible = cmp_valid_reg & pend_reg[cmp_idx_reg] & ~act_reg[cmp_idx_reg];
  wire take = eligible & (~cand_valid_reg | (mem_rdata < cand_pri_reg));
  wire wrap = cmp_valid_reg & (cmp_idx_reg == LAST_IDX);
  wire cand_valid_next = cand_valid_reg | take;
  wire [IDX_W-1:0] cand_idx_next = take ? cmp_idx_reg : cand_idx_reg;
  wire [PRIO_W-1:0] cand_pri_next = take ? mem_rdata : cand_pri_reg;

  // An ack restarts the sweep so a stale winner is never reported
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_idx_reg <= '0;
      cmp_idx_reg <= '0;
      cmp_valid_reg <= 1'b0;
      cand_valid_reg <= 1'b0;
      cand_idx_reg <= '0;
      cand_pri_reg <= '0;
      best_valid_reg <= 1'b0;
      best_idx_reg <= '0;
      best_pri_reg <= '0;
    end else if (rd_ack) begin
      scan_idx_reg <= '0;
      cmp_valid_reg <= 1'b0;
      cand_valid_reg <= 1'b0;
      best_valid_reg <= 1'b0;
    end else begin
      scan_idx_reg <= (scan_idx_reg == LAST_IDX) ? '0 : scan_idx_reg + 1'b1;
      cmp_idx_reg <= scan_idx_reg;
      cmp_valid_reg <= 1'b1;
      cand_valid_reg <= wrap ? 1'b0 : cand_valid_next;
      cand_idx_reg <= cand_idx_next;
      cand_pri_reg <= cand_pri_next;
      if (wrap) begin
        best_valid_reg <= cand_valid_next;
        best_idx_reg <= cand_idx_next;
        best_pri_reg <= cand_pri_next;
      end
    end
  end

  // Request routing
  wire sig_g0 = sig_ok & ~best_grp1 & ctl_reg[`CTL_G0EN];
  wire sig_g1 = sig_ok & best_grp1 & ctl_reg[`CTL_G1EN];
  wire iface_off = ~ctl_reg[`CTL_G0EN] & ~ctl_reg[`CTL_G1EN];
  wire byp_irq = byp_irq_sync & ~ctl_reg[`CTL_IRQ_BYP_DIS] & iface_off;
  wire byp_fast = byp_fast_sync & ~ctl_reg[`CTL_FAST_BYP_DIS] & iface_off;
  wire irq_next = sig_g1 | (sig_g0 & ~ctl_reg[`CTL_FAST_EN]) | byp_irq;
  wire fast_next = (sig_g0 & ctl_reg[`CTL_FAST_EN]) | byp_fast;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req_reg <= 1'b0;
      fast_req_reg <= 1'b0;
    end else begin
      irq_req_reg <= irq_next;
      fast_req_reg <= fast_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pready_reg & err_reg;
  assign irq_req = irq_req_reg;
  assign fast_interrupt_request = fast_req_reg;

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wait_answer;
    psel && penable && !pready ##1 psel && penable && pready;
  endsequence

  chk_apb_wait_state: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup ##1 (psel && penable) |-> s_wait_answer)
    else $error("APB answer not after exactly one wait state");
  chk_grp1_on_irq: assert property (@(posedge pclk) disable iff (!presetn)
    (sig_ok && best_grp1 && ctl_reg[`CTL_G1EN]) |=> (irq_req && !fast_interrupt_request))
    else $error("Group 1 interrupt not on IRQ line");
  chk_grp0_fast_route: assert property (@(posedge pclk) disable iff (!presetn)
    (sig_ok && !best_grp1 && ctl_reg[`CTL_G0EN]) |=>
      (fast_interrupt_request == $past(ctl_reg[`CTL_FAST_EN])) && (irq_req == !$past(ctl_reg[`CTL_FAST_EN])))
    else $error("Group 0 interrupt on wrong request line");
  chk_grp0_disabled: assert property (@(posedge pclk) disable iff (!presetn)
    (sig_ok && !best_grp1 && !ctl_reg[`CTL_G0EN] && ctl_reg[`CTL_G1EN]) |=> (!irq_req && !fast_interrupt_request))
    else $error("Disabled Group 0 interrupt signalled");
  chk_mask_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (pmr_reg == '0 && !iface_off) |=> (!irq_req && !fast_interrupt_request))
    else $error("Interrupt signalable with zero mask");
  chk_spurious_1022: assert property (@(posedge pclk) disable iff (!presetn)
    (cap && !pwrite && paddr == `OFF_IAR && sec_acc && sig_ok && best_grp1 && !ctl_reg[`CTL_ACK_CONTROL])
      |=> (pready && prdata[`ID_W-1:0] == `ID_SPUR_GRP) ##1 (act_reg == $past(act_reg, 2)))
    else $error("Primary ack of Group 1 did not return 1022");
  chk_spurious_1023: assert property (@(posedge pclk) disable iff (!presetn)
    (cap && !pwrite && ack_addr && !refuse && !sig_ok) |=> (pready && prdata[`ID_W-1:0] == `ID_SPUR_NONE))
    else $error("Ack with nothing signalable did not return 1023");
  chk_alias_grp0: assert property (@(posedge pclk) disable iff (!presetn)
    (cap && !pwrite && paddr == `OFF_AIAR && !refuse && sig_ok && !best_grp1)
      |=> (prdata[`ID_W-1:0] == `ID_SPUR_NONE) && !ack_take_reg)
    else $error("Alias ack took a Group 0 interrupt");
  chk_ack_moves: assert property (@(posedge pclk) disable iff (!presetn)
    rd_ack |=> (act_reg[$past(ack_idx_reg)] && !best_valid_reg && prdata[`ID_W-1:0] == irq_id_t'($past(ack_idx_reg))))
    else $error("Acknowledge did not activate the interrupt");
  chk_no_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && !pslverr && !pwrite && ack_addr) |-> (prdata[`ID_W-1:0] != 10'h3fc && prdata[`ID_W-1:0] != 10'h3fd))
    else $error("Reserved identifier delivered");
  chk_alias_secure: assert property (@(posedge pclk) disable iff (!presetn)
    (cap && alias_hit && ns_acc) |=> pslverr)
    else $error("Alias register answered a nonsecure access");
endmodule : interrupt_group_ack_logic

//--- testbench/core_model.sv
`timescale 1ns/1ps
module core_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Requests from the interrupt interface
  input wire logic irq_req,
  input wire logic fast_interrupt_request,
  // Request levels as the core sampled them
  output logic core_irq,
  output logic core_fast
);
  // Core only samples its pins; it answers through register reads made by the bench
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_irq <= 1'b0;
      core_fast <= 1'b0;
    end else begin
      core_irq <= irq_req;
      core_fast <= fast_interrupt_request;
    end
  end
endmodule : core_model

//--- testbench/testbench.sv
`timescale 1ns/1ps
`include "irq_group_regs.svh"
module testbench;
  import irq_group_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic byp_irq, byp_fast, irq_req, fast_req, core_irq, core_fast, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] pprot;
  logic [7:0] src;
  int bad_count, n_tests;

  interrupt_group_ack_logic #(.NUM_IRQ(8)) interrupt_group_ack_logic_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pprot(pprot),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_src_in(src), .bypass_irq_in(byp_irq),
    .bypass_fast_in(byp_fast), .irq_req(irq_req), .fast_interrupt_request(fast_req));
  core_model core_model_inst (.pclk(pclk), .presetn(presetn), .irq_req(irq_req),
    .fast_interrupt_request(fast_req), .core_irq(core_irq), .core_fast(core_fast));

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic ns);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pprot <= {1'b0, ns, 1'b0};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask : wr

  task rd_id(input string what, input logic [11:0] a, input logic ns, input logic [9:0] exp);
    apb(1'b0, a, 32'h0, ns);
    check(what, {22'h0, exp}, {22'h0, rd[9:0]});
  endtask : rd_id

  task rd_reg(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 1'b0);
    check(what, exp, rd);
  endtask : rd_reg

  // Long enough for two full pending sweeps of 8 sources plus sync
  task settle;
    repeat (40) @(posedge pclk);
  endtask : settle

  task expect_req(input logic ei, input logic ef);
    settle();
    check("core irq", {31'h0, ei}, {31'h0, core_irq});
    check("core fast", {31'h0, ef}, {31'h0, core_fast});
  endtask : expect_req

  task t_reset;
    rd_reg("control", `OFF_CTL, 32'h0);
    rd_reg("group bits", `OFF_GROUP, 32'h0);
    expect_req(1'b0, 1'b0);
    $display("test reset done");
  endtask : t_reset

  task t_route;
    // Group 0 ranked above Group 1, as software must
    wr(12'h100, 32'h10);
    wr(12'h104, 32'h80);
    wr(`OFF_PMR, 32'hff);
    src[0] <= 1'b1;
    wr(`OFF_CTL, 32'h1);
    expect_req(1'b1, 1'b0);
    wr(`OFF_CTL, 32'h9);
    expect_req(1'b0, 1'b1);
    wr(`OFF_CTL, 32'ha);
    expect_req(1'b0, 1'b0);
    $display("test routing done");
  endtask : t_route

  task t_ack0;
    wr(`OFF_CTL, 32'h9);
    settle();
    rd_id("alias ack g0", `OFF_AIAR, 1'b0, 10'h3ff);
    rd_id("nonsecure ack g0", `OFF_IAR, 1'b1, 10'h3ff);
    rd_id("secure ack g0", `OFF_IAR, 1'b0, 10'h0);
    settle();
    rd_reg("pending", `OFF_PEND, 32'h0);
    rd_reg("active", `OFF_ACT, 32'h1);
    wr(`OFF_EOIR, 32'h0);
    rd_reg("active after eoi", `OFF_ACT, 32'h0);
    $display("test group 0 ack done");
  endtask : t_ack0

  task t_grp1;
    wr(`OFF_GROUP, 32'h2);
    src[1] <= 1'b1;
    wr(`OFF_CTL, 32'hb);
    expect_req(1'b1, 1'b0);
    rd_id("primary ack g1", `OFF_IAR, 1'b0, 10'h3fe);
    apb(1'b0, `OFF_AIAR, 32'h0, 1'b1);
    check("nonsecure alias error", 32'h1, {31'h0, err});
    rd_id("alias pending", `OFF_AHPPIR, 1'b0, 10'h1);
    rd_id("alias ack g1", `OFF_AIAR, 1'b0, 10'h1);
    wr(`OFF_AEOIR, 32'h1);
    $display("test group 1 ack done");
  endtask : t_grp1

  task t_acknowledge_control;
    src[1] <= 1'b0;
    settle();
    src[1] <= 1'b1;
    wr(`OFF_CTL, 32'hf);
    settle();
    rd_id("acknowledge_control primary", `OFF_IAR, 1'b0, 10'h1);
    wr(`OFF_AEOIR, 32'h1);
    src[1] <= 1'b0;
    settle();
    src[1] <= 1'b1;
    wr(`OFF_PMR, 32'h0);
    expect_req(1'b0, 1'b0);
    rd_id("masked ack", `OFF_AIAR, 1'b0, 10'h3ff);
    rd_reg("pending kept", `OFF_PEND, 32'h2);
    wr(`OFF_PMR, 32'hff);
    wr(`OFF_CTL, 32'hb);
    settle();
    rd_id("nonsecure ack g1", `OFF_IAR, 1'b1, 10'h1);
    $display("test ack control and mask done");
  endtask : t_acknowledge_control

  task t_misc;
    wr(`OFF_BPR, 32'h3);
    wr(`OFF_ABPR, 32'h5);
    wr(`OFF_CTL, 32'h0);
    apb(1'b0, `OFF_STATUS, 32'h0, 1'b0);
    check("group 1 point", 32'h5, {29'h0, rd[18:16]});
    wr(`OFF_CTL, 32'h10);
    apb(1'b0, `OFF_STATUS, 32'h0, 1'b0);
    check("common point", 32'h3, {29'h0, rd[18:16]});
    wr(`OFF_CTL, 32'h0);
    byp_irq <= 1'b1;
    byp_fast <= 1'b1;
    expect_req(1'b1, 1'b1);
    wr(`OFF_CTL, 32'h60);
    expect_req(1'b0, 1'b0);
    apb(1'b0, 12'h03c, 32'h0, 1'b0);
    check("unmapped error", 32'h1, {31'h0, err});
    $display("test binary point and bypass done");
  endtask : t_misc

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, byp_irq, byp_fast} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pprot = 3'h0;
    src = 8'h0;
    bad_count = 0;
    n_tests = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_route();
    t_ack0();
    t_grp1();
    t_acknowledge_control();
    t_misc();
    report_and_stop();
  end
endmodule : testbench
